// ---- port_flags_pkg.sv ----
// constants shared by the serial port status and control slice
package port_flags_pkg;

  // ****************************************************************
  // register offsets on the plain register port
  // ****************************************************************
  localparam logic [2:0] OFS_CONTROL_ONE  = 3'h0;
  localparam logic [2:0] OFS_STATUS       = 3'h1;
  localparam logic [2:0] OFS_SHIFT_BUF    = 3'h2;
  localparam logic [2:0] OFS_SLAVE_ADDR   = 3'h3;
  localparam logic [2:0] OFS_MASTER_SEQ   = 3'h4;
  localparam logic [2:0] OFS_IRQ_STATUS   = 3'h5;
  localparam logic [2:0] OFS_IRQ_MASK     = 3'h6;

  // ****************************************************************
  // control one field positions
  // ****************************************************************
  localparam int CTL_WRITE_COLLISION_FLAG_POS  = 7;
  localparam int CTL_OVF_POS   = 6;
  localparam int CTL_EN_POS    = 5;
  localparam int CTL_CKR_POS   = 4;
  localparam int CTL_MODE_MSB  = 3;

  // ****************************************************************
  // status field positions
  // ****************************************************************
  localparam int ST_BF_POS     = 0;
  localparam int ST_UA_POS     = 1;
  localparam int ST_RW_POS     = 2;
  localparam int ST_RWV_POS    = 3;
  localparam int ST_IDLE_POS   = 4;

  // ****************************************************************
  // master sequence enable positions
  // ****************************************************************
  localparam int SEQ_START_POS = 0;
  localparam int SEQ_RSTRT_POS = 1;
  localparam int SEQ_STOP_POS  = 2;
  localparam int SEQ_RCV_POS   = 3;
  localparam int SEQ_ACK_POS   = 4;
  localparam int SEQ_W         = 5;

  // ****************************************************************
  // interrupt event positions
  // ****************************************************************
  localparam int IRQ_RX_POS    = 0;
  localparam int IRQ_UA_POS    = 1;
  localparam int IRQ_MATCH_POS = 2;
  localparam int IRQ_STOP_POS  = 3;
  localparam int IRQ_W         = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_RST  = 8'h00;
  localparam logic [7:0] SHIFT_BUF_RST   = 8'h00;
  localparam logic [4:0] MASTER_SEQ_RST  = 5'h00;
  localparam logic [3:0] IRQ_MASK_RST    = 4'h0;

  // ****************************************************************
  // mode select codes
  // ****************************************************************
  localparam logic [3:0] MODE_SLV7       = 4'h6;
  localparam logic [3:0] MODE_SLV10      = 4'h7;
  localparam logic [3:0] MODE_MASTER     = 4'h8;
  localparam logic [3:0] MODE_FW_MASTER  = 4'hb;
  localparam logic [3:0] MODE_SLV7_IRQ   = 4'he;
  localparam logic [3:0] MODE_SLV10_IRQ  = 4'hf;

endpackage

// ---- sticky_irq_bank.sv ----
// sticky event bits with write-one-to-clear, a mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none

module sticky_irq_bank #(
  parameter int W = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic         clr_wr_in,
  input  wire logic         mask_wr_in,
  input  wire logic [W-1:0] wdata_in,
  output logic      [W-1:0] status_out,
  output logic      [W-1:0] mask_out,
  output logic              irq_out
);

  logic [W-1:0] pend_nxt;
  logic [W-1:0] mask_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // an event in the clearing cycle survives
      assign pend_nxt[gi] = set_in[gi] | (status_out[gi] & ~(clr_wr_in & wdata_in[gi]));
    end
  endgenerate

  assign mask_nxt = mask_wr_in ? wdata_in : mask_out;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_out <= '0;
      mask_out   <= '0;
      irq_out    <= 1'b0;
    end else if (ce_in) begin
      status_out <= pend_nxt;
      mask_out   <= mask_nxt;
      irq_out    <= |(pend_nxt & mask_nxt);
    end
  end

endmodule

`default_nettype wire

// ---- i2c_port_status_flags.sv ----
// status flags and main control register of the i2c serial port
`timescale 1ns/1ps
`default_nettype none

module i2c_port_status_flags (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       ce_in,
  // register port
  input  wire logic [2:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // events from the bus engine, same clock
  input  wire logic       addr_match_in,
  input  wire logic       addr_rw_in,
  input  wire logic       addr_upd_req_in,
  input  wire logic       start_det_in,
  input  wire logic       stop_det_in,
  input  wire logic       nack_det_in,
  input  wire logic       rx_done_in,
  input  wire logic [7:0] rx_byte_in,
  input  wire logic       tx_busy_in,
  input  wire logic [4:0] seq_done_in,
  // state toward the bus engine
  output logic            port_enable_out,
  output logic            clock_release_out,
  output logic      [3:0] mode_out,
  output logic      [4:0] seq_enable_out,
  output logic      [7:0] slave_addr_out,
  output logic      [7:0] tx_byte_out,
  output logic            tx_load_out,
  output logic            rw_bit_out,
  output logic            rw_valid_out,
  output logic            idle_out,
  output logic            irq_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic is_master(input logic [3:0] m);
    is_master = (m == port_flags_pkg::MODE_MASTER) || (m == port_flags_pkg::MODE_FW_MASTER);
  endfunction

  function automatic logic is_ten_bit(input logic [3:0] m);
    is_ten_bit = (m == port_flags_pkg::MODE_SLV10) || (m == port_flags_pkg::MODE_SLV10_IRQ);
  endfunction

  function automatic logic is_slave(input logic [3:0] m);
    is_slave = (m == port_flags_pkg::MODE_SLV7) || (m == port_flags_pkg::MODE_SLV7_IRQ) ||
               is_ten_bit(m);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] control_one_r;
  logic [7:0] control_one_nxt;
  logic [7:0] shift_buffer_reg_r;
  logic [7:0] shift_buffer_reg_nxt;
  logic [7:0] slave_address_reg_r;
  logic [7:0] slave_address_reg_nxt;
  logic [7:0] tx_byte_r;
  logic [4:0] seq_enable_r;
  logic [4:0] seq_enable_nxt;
  logic       buffer_full_flag_r;
  logic       buffer_full_flag_nxt;
  logic       address_update_needed_r;
  logic       address_update_needed_nxt;
  logic       rw_capt_r;
  logic       rw_capt_nxt;
  logic       rw_valid_r;
  logic       rw_valid_nxt;
  logic       tx_load_r;
  logic       idle_r;
  logic       idle_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // ****************************************************************
  // access decode
  // ****************************************************************
  wire logic wr_ctl   = reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_CONTROL_ONE);
  wire logic wr_buf   = reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_SHIFT_BUF);
  wire logic wr_sadr  = reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_SLAVE_ADDR);
  wire logic wr_seq   = reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_MASTER_SEQ);
  wire logic wr_iclr  = reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_IRQ_STATUS);
  wire logic wr_imask = reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_IRQ_MASK);
  wire logic rd_buf   = reg_rd_in && (reg_addr_in == port_flags_pkg::OFS_SHIFT_BUF);

  wire logic [3:0] mode_sel = control_one_r[port_flags_pkg::CTL_MODE_MSB:0];
  wire logic       enabled  = control_one_r[port_flags_pkg::CTL_EN_POS];
  wire logic       in_slave = enabled && is_slave(mode_sel);
  wire logic       in_mast  = enabled && is_master(mode_sel);

  // engine events other than seq_done_in count only while the port is switched on
  wire logic ev_match = enabled && addr_match_in;
  wire logic ev_rx    = enabled && rx_done_in;
  wire logic ev_stop  = enabled && stop_det_in;
  wire logic ev_end   = enabled && (start_det_in || stop_det_in || nack_det_in);

  // ****************************************************************
  // control one
  // ****************************************************************
  // collision: buffer written while a transfer still runs
  wire logic set_write_collision_flag = enabled && wr_buf && tx_busy_in;
  // overflow: a byte arrives while the previous one is unread
  wire logic set_ovf  = ev_rx && buffer_full_flag_r && !rd_buf;

  always_comb begin
    // both flags are also writable to zero, which is how software clears them
    control_one_nxt = wr_ctl ? reg_wdata_in : control_one_r;
    // hardware set wins over a software write of zero
    if (set_write_collision_flag) begin
      control_one_nxt[port_flags_pkg::CTL_WRITE_COLLISION_FLAG_POS] = 1'b1;
    end
    if (set_ovf) begin
      control_one_nxt[port_flags_pkg::CTL_OVF_POS] = 1'b1;
    end
  end

  // ****************************************************************
  // shift buffer and buffer-full flag
  // ****************************************************************
  // an overflowing byte is dropped so the unread one is kept
  assign shift_buffer_reg_nxt = (ev_rx && !set_ovf) ? rx_byte_in : shift_buffer_reg_r;

  // set on arrival, cleared by reading the buffer; arrival wins
  assign buffer_full_flag_nxt = ev_rx ? 1'b1 : (rd_buf ? 1'b0 : buffer_full_flag_r);

  // ****************************************************************
  // slave address and update request
  // ****************************************************************
  assign slave_address_reg_nxt = wr_sadr ? reg_wdata_in : slave_address_reg_r;

  // reload by software lowers the flag unless a new request lands
  assign address_update_needed_nxt =
    (in_slave && is_ten_bit(mode_sel) && addr_upd_req_in) ? 1'b1 :
    ((wr_sadr || !is_ten_bit(mode_sel) || !enabled) ? 1'b0 : address_update_needed_r);

  // ****************************************************************
  // direction bit capture and its validity window
  // ****************************************************************
  assign rw_capt_nxt  = (in_slave && ev_match) ? addr_rw_in : rw_capt_r;
  // a match in the same cycle as an ending condition opens a new window
  assign rw_valid_nxt = (in_slave && ev_match) ? 1'b1 :
                        ((ev_end || !in_slave) ? 1'b0 : rw_valid_r);

  // ****************************************************************
  // master sequence enables
  // ****************************************************************
  // writes outside master mode are dropped so a slave can never launch a sequence
  genvar gs;
  generate
    for (gs = 0; gs < port_flags_pkg::SEQ_W; gs++) begin : g_seq
      // the engine lowers an enable when its sequence finishes
      assign seq_enable_nxt[gs] = (wr_seq && in_mast) ? reg_wdata_in[gs] :
                                  (seq_done_in[gs] ? 1'b0 : seq_enable_r[gs]);
    end
  endgenerate

  // ****************************************************************
  // idle derivation
  // ****************************************************************
  // bit 2 of status means transmit-in-progress for a master, direction for a slave
  wire logic dir_or_tx = in_mast ? tx_busy_in : (rw_capt_r & rw_valid_r);
  assign idle_nxt = !(dir_or_tx || (|seq_enable_r));

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [port_flags_pkg::IRQ_W-1:0] irq_set;
  logic [port_flags_pkg::IRQ_W-1:0] irq_status;
  logic [port_flags_pkg::IRQ_W-1:0] irq_mask;

  always_comb begin
    irq_set = '0;
    irq_set[port_flags_pkg::IRQ_RX_POS]    = ev_rx;
    irq_set[port_flags_pkg::IRQ_UA_POS]    = address_update_needed_nxt && !address_update_needed_r;
    irq_set[port_flags_pkg::IRQ_MATCH_POS] = in_slave && ev_match;
    irq_set[port_flags_pkg::IRQ_STOP_POS]  = ev_stop;
  end

  // the bank shares the enable, so a frozen port neither loses nor invents an event
  sticky_irq_bank #(
    .W (port_flags_pkg::IRQ_W)
  ) u_irq (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .ce_in       (ce_in),
    .set_in      (irq_set),
    .clr_wr_in   (wr_iclr),
    .mask_wr_in  (wr_imask),
    .wdata_in    (reg_wdata_in[port_flags_pkg::IRQ_W-1:0]),
    .status_out  (irq_status),
    .mask_out    (irq_mask),
    .irq_out     (irq_out)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  // outside its valid window bit 2 keeps a stale direction; software must test bit 3 first
  logic [7:0] status_word;

  always_comb begin
    status_word = 8'h00;
    status_word[port_flags_pkg::ST_BF_POS]   = buffer_full_flag_r;
    status_word[port_flags_pkg::ST_UA_POS]   = address_update_needed_r;
    status_word[port_flags_pkg::ST_RW_POS]   = in_mast ? tx_busy_in : rw_capt_r;
    status_word[port_flags_pkg::ST_RWV_POS]  = rw_valid_r;
    status_word[port_flags_pkg::ST_IDLE_POS] = idle_r;
  end

  // idle cycles return zero so a late sample never shows a stale register
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        port_flags_pkg::OFS_CONTROL_ONE: rdata_nxt = control_one_r;
        port_flags_pkg::OFS_STATUS:      rdata_nxt = status_word;
        port_flags_pkg::OFS_SHIFT_BUF:   rdata_nxt = shift_buffer_reg_r;
        port_flags_pkg::OFS_SLAVE_ADDR:  rdata_nxt = slave_address_reg_r;
        port_flags_pkg::OFS_MASTER_SEQ:  rdata_nxt = {3'h0, seq_enable_r};
        port_flags_pkg::OFS_IRQ_STATUS:  rdata_nxt = {4'h0, irq_status};
        port_flags_pkg::OFS_IRQ_MASK:    rdata_nxt = {4'h0, irq_mask};
        default:                         rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control_one_r           <= port_flags_pkg::CONTROL_ONE_RST;
      shift_buffer_reg_r      <= port_flags_pkg::SHIFT_BUF_RST;
      slave_address_reg_r     <= port_flags_pkg::SLAVE_ADDR_RST;
      seq_enable_r            <= port_flags_pkg::MASTER_SEQ_RST;
      buffer_full_flag_r      <= 1'b0;
      address_update_needed_r <= 1'b0;
      rw_capt_r               <= 1'b0;
      rw_valid_r              <= 1'b0;
      idle_r                  <= 1'b1;
      rdata_r                 <= 8'h00;
    end else if (ce_in) begin
      control_one_r           <= control_one_nxt;
      shift_buffer_reg_r      <= shift_buffer_reg_nxt;
      slave_address_reg_r     <= slave_address_reg_nxt;
      seq_enable_r            <= seq_enable_nxt;
      buffer_full_flag_r      <= buffer_full_flag_nxt;
      address_update_needed_r <= address_update_needed_nxt;
      rw_capt_r               <= rw_capt_nxt;
      rw_valid_r              <= rw_valid_nxt;
      idle_r                  <= idle_nxt;
      rdata_r                 <= rdata_nxt;
    end
  end

  // tx path: a refused write (collision) loads nothing
  wire logic tx_accept = wr_buf && enabled && !tx_busy_in;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_byte_r <= 8'h00;
      tx_load_r <= 1'b0;
    end else if (ce_in) begin
      tx_load_r <= tx_accept;
      if (tx_accept) begin
        tx_byte_r <= reg_wdata_in;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_out     = rdata_r;
  assign port_enable_out   = control_one_r[port_flags_pkg::CTL_EN_POS];
  assign clock_release_out = control_one_r[port_flags_pkg::CTL_CKR_POS];
  assign mode_out          = control_one_r[port_flags_pkg::CTL_MODE_MSB:0];
  assign seq_enable_out    = seq_enable_r;
  assign slave_addr_out    = slave_address_reg_r;
  assign tx_byte_out       = tx_byte_r;
  assign tx_load_out       = tx_load_r;
  assign rw_bit_out        = rw_capt_r;
  assign rw_valid_out      = rw_valid_r;
  assign idle_out          = idle_r;

endmodule

`default_nettype wire

// ---- port_flags_asserts.sv ----
// concurrent checks on the serial port status and control slice
`timescale 1ns/1ps
`default_nettype none

module port_flags_asserts (
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       ce_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       addr_match_in,
  input wire logic       addr_rw_in,
  input wire logic       start_det_in,
  input wire logic       stop_det_in,
  input wire logic       nack_det_in,
  input wire logic       tx_busy_in,
  input wire logic       port_enable_out,
  input wire logic       clock_release_out,
  input wire logic [3:0] mode_out,
  input wire logic [4:0] seq_enable_out,
  input wire logic       rw_bit_out,
  input wire logic       rw_valid_out,
  input wire logic       idle_out
);
  wire slave_mode;
  wire ev_ok;
  wire ctl_wr;
  wire bus_end;
  assign slave_mode = (mode_out == port_flags_pkg::MODE_SLV7) ||
                      (mode_out == port_flags_pkg::MODE_SLV10) ||
                      (mode_out == port_flags_pkg::MODE_SLV7_IRQ) ||
                      (mode_out == port_flags_pkg::MODE_SLV10_IRQ);
  assign ev_ok = ce_in && port_enable_out;
  assign ctl_wr = ce_in && reg_wr_in && (reg_addr_in == port_flags_pkg::OFS_CONTROL_ONE);
  assign bus_end = start_det_in || stop_det_in || nack_det_in;

  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // ****************************************************************
  // direction bit and its valid window
  // ****************************************************************
  rw_capture_a : assert property (
    ev_ok && slave_mode && addr_match_in |=> rw_valid_out && rw_bit_out == $past(addr_rw_in))
    else $error("direction bit not captured on address match");
  rw_close_a : assert property (
    ev_ok && bus_end && !addr_match_in |=> !rw_valid_out)
    else $error("direction valid survived a bus condition");
  rw_origin_a : assert property (
    $rose(rw_valid_out) |-> $past(addr_match_in))
    else $error("direction valid rose without address match");
  rw_hold_a : assert property (
    ev_ok && slave_mode && rw_valid_out && !bus_end && !addr_match_in && !ctl_wr
    |=> rw_valid_out && $stable(rw_bit_out))
    else $error("direction window closed or changed early");

  // ****************************************************************
  // idle indication and control register
  // ****************************************************************
  idle_seq_a : assert property (
    ce_in && (seq_enable_out != 5'h00) |=> !idle_out)
    else $error("idle while a sequence enable is set");
  idle_dir_a : assert property (
    ce_in && slave_mode && rw_valid_out && rw_bit_out |=> !idle_out)
    else $error("idle while slave read is in progress");
  idle_free_a : assert property (
    ce_in && (seq_enable_out == 5'h00) && !rw_valid_out && !tx_busy_in |=> idle_out)
    else $error("not idle with every busy source clear");
  ctl_write_a : assert property (
    ctl_wr |=> {port_enable_out, clock_release_out, mode_out} == $past(reg_wdata_in[5:0]))
    else $error("control write not reflected on outputs");
  ctl_hold_a : assert property (
    !ctl_wr |=> $stable({port_enable_out, clock_release_out, mode_out}))
    else $error("control outputs moved without a write");
endmodule

bind i2c_port_status_flags port_flags_asserts chk_i (
  .core_clk_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .addr_match_in, .addr_rw_in, .start_det_in, .stop_det_in, .nack_det_in, .tx_busy_in,
  .port_enable_out, .clock_release_out, .mode_out, .seq_enable_out,
  .rw_bit_out, .rw_valid_out, .idle_out
);

`default_nettype wire

// ---- bus_engine_model.sv ----
// behavioural model of the bus engine that feeds events to the slice
`timescale 1ns/1ps
`default_nettype none

module bus_engine_model (
  input  wire logic       core_clk_in,
  output logic      [5:0] ev_out,
  output logic            rw_out,
  output logic      [7:0] byte_out,
  output logic            busy_out,
  output logic      [4:0] seq_done_out
);
  initial begin
    ev_out = 6'h00;
    rw_out = 1'b0;
    byte_out = 8'h00;
    busy_out = 1'b0;
    seq_done_out = 5'h00;
  end

  // one cycle event k: 0 match, 1 address update, 2 start, 3 stop, 4 nack, 5 rx done
  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge core_clk_in);
    ev_out[k] <= 1'b1;
    rw_out <= d[0];
    byte_out <= d;
    @(posedge core_clk_in);
    ev_out <= 6'h00;
    // stale data is flipped so the slice cannot lean on it after the pulse
    rw_out <= ~d[0];
    byte_out <= ~d;
    #1;
  endtask

  task automatic seq(input int i);
    @(posedge core_clk_in);
    seq_done_out <= 5'h01 << i;
    @(posedge core_clk_in);
    seq_done_out <= 5'h00;
  endtask

  task automatic busy(input logic v);
    @(posedge core_clk_in);
    busy_out <= v;
  endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the serial port status and control slice
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [2:0] A_CTL = port_flags_pkg::OFS_CONTROL_ONE;
  localparam logic [2:0] A_ST  = port_flags_pkg::OFS_STATUS;
  localparam logic [2:0] A_BUF = port_flags_pkg::OFS_SHIFT_BUF;
  localparam logic [2:0] A_SAD = port_flags_pkg::OFS_SLAVE_ADDR;
  localparam logic [2:0] A_SEQ = port_flags_pkg::OFS_MASTER_SEQ;
  localparam logic [2:0] A_IRQ = port_flags_pkg::OFS_IRQ_STATUS;
  localparam logic [2:0] A_MSK = port_flags_pkg::OFS_IRQ_MASK;
  logic       core_clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] rdata;
  logic [5:0] ev;
  logic       rw;
  logic [7:0] rx_byte;
  logic       busy;
  logic [4:0] seq_done;
  logic       irq;
  logic       ce = 1'b1;
  logic [7:0] sadr;
  logic [7:0] txb;
  logic       txl;
  int         fail_count = 0;
  int         n_compared = 0;

  always #5 core_clk_in = ~core_clk_in;

  bus_engine_model pm (.core_clk_in(core_clk_in), .ev_out(ev), .rw_out(rw),
    .byte_out(rx_byte), .busy_out(busy), .seq_done_out(seq_done));

  i2c_port_status_flags uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .ce_in(ce),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .addr_match_in(ev[0]), .addr_rw_in(rw), .addr_upd_req_in(ev[1]),
    .start_det_in(ev[2]), .stop_det_in(ev[3]), .nack_det_in(ev[4]), .rx_done_in(ev[5]),
    .rx_byte_in(rx_byte), .tx_busy_in(busy), .seq_done_in(seq_done), .port_enable_out(),
    .clock_release_out(), .mode_out(), .seq_enable_out(), .slave_addr_out(sadr),
    .tx_byte_out(txb), .tx_load_out(txl), .rw_bit_out(), .rw_valid_out(), .idle_out(),
    .irq_out(irq));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk_in);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic irqchk(input logic exp);
    @(posedge core_clk_in);
    #1;
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  task automatic test_done;
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (12) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rdchk(A_CTL, 8'h00);
    rdchk(A_ST, 8'h10);
    for (int i = 0; i < 8; i++) begin
      wr(A_CTL, 8'h01 << i);
      rdchk(A_CTL, 8'h01 << i);
    end
    wr(3'h7, 8'hff);
    rdchk(3'h7, 8'h00);
    rdchk(A_CTL, 8'h80);
    // receive path in ten-bit slave mode, with overflow on a second byte
    wr(A_CTL, 8'h27);
    wr(A_MSK, 8'h0f);
    pm.pulse(5, 8'h55);
    rdchk(A_ST, 8'h11);
    irqchk(1'b1);
    wr(A_MSK, 8'h00);
    irqchk(1'b0);
    wr(A_MSK, 8'h0f);
    irqchk(1'b1);
    pm.pulse(5, 8'h66);
    rdchk(A_CTL, 8'h67);
    rdchk(A_BUF, 8'h55);
    rdchk(A_ST, 8'h10);
    wr(A_IRQ, 8'h0f);
    irqchk(1'b0);
    // address reload request only counts in ten-bit slave mode
    pm.pulse(1, 8'h00);
    rdchk(A_ST, 8'h12);
    wr(A_SAD, 8'h3c);
    rdchk(A_ST, 8'h10);
    chk(sadr, 8'h3c);
    wr(A_CTL, 8'h26);
    pm.pulse(1, 8'h00);
    rdchk(A_ST, 8'h10);
    // each of start, stop and nack closes the direction window
    for (int k = 2; k < 5; k++) begin
      pm.pulse(0, (k % 2) ? 8'h01 : 8'h00);
      rdchk(A_ST, (k % 2) ? 8'h0c : 8'h18);
      pm.pulse(k, 8'h00);
      @(posedge core_clk_in);
      rdchk(A_ST, (k % 2) ? 8'h14 : 8'h10);
    end
    // master mode: every sequence enable and transmit activity block idle
    // a write while the clock enable is low is lost
    @(posedge core_clk_in);
    ce <= 1'b0;
    wr(A_CTL, 8'h00);
    ce <= 1'b1;
    rdchk(A_CTL, 8'h26);
    wr(A_CTL, 8'h28);
    for (int i = 0; i < 5; i++) begin
      wr(A_SEQ, 8'h01 << i);
      @(posedge core_clk_in);
      rdchk(A_ST, 8'h00);
      pm.seq(i);
      @(posedge core_clk_in);
      rdchk(A_ST, 8'h10);
    end
    // an accepted buffer write loads the byte and pulses the load strobe once
    wr(A_BUF, 8'ha5);
    #1;
    chk(txb, 8'ha5);
    chk({7'h00, txl}, 8'h01);
    pm.busy(1'b1);
    @(posedge core_clk_in);
    rdchk(A_ST, 8'h04);
    // a buffer write during a transfer raises the collision bit and loads nothing
    wr(A_BUF, 8'h5a);
    rdchk(A_CTL, 8'ha8);
    chk(txb, 8'ha5);
    chk({7'h00, txl}, 8'h00);
    pm.busy(1'b0);
    @(posedge core_clk_in);
    rdchk(A_ST, 8'h10);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    fail_count++;
    test_done();
  end
endmodule

`default_nettype wire
